// [pkg/port_pkg.sv]
package port_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT0   = 8'h80;
  localparam logic [7:0] ADDR_PORT1   = 8'h90;
  localparam logic [7:0] ADDR_MOD_SEL = 8'h9f;
  localparam logic [7:0] ADDR_PORT2   = 8'ha0;
  localparam logic [7:0] ADDR_CFG     = 8'haf;
  localparam logic [7:0] ADDR_PU0     = 8'hb2;
  localparam logic [7:0] ADDR_PU1     = 8'hb3;
  localparam logic [7:0] ADDR_PU2     = 8'hb4;

  // ----------------------------------------------------------------
  // Fields, masks and reset values
  // ----------------------------------------------------------------
  localparam int         MOD_EN_BIT     = 4;
  localparam logic [7:0] LATCH_RESET    = 8'hff;
  localparam logic [7:0] PU_RESET       = 8'h00;
  localparam logic [7:0] MOD_SEL_RESET  = 8'h00;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] FULL_MASK      = 8'hff;
  localparam logic [7:0] PU2_MASK       = 8'h27;
  localparam logic [7:0] CFG_MASK       = 8'h10;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  localparam int NUM_PORTS = 3;
  localparam int PORT_W    = 8;
  localparam int NUM_PINS  = 24;
  localparam int NUM_MOD   = 8;

  // Select bit n modulates pin MOD_PIN[n] (port * 8 + bit)
  localparam int MOD_PIN [NUM_MOD] = '{3, 5, 7, 2, 9, 19, 13, 14};

  // ----------------------------------------------------------------
  // Carrier timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 200;
  localparam int CARRIER_KHZ  = 38;
  localparam int CARRIER_HALF = (CLK_MHZ * 1000) / (2 * CARRIER_KHZ);
  localparam int CNT_W        = 12;

endpackage

// [hdl/parallel_port.sv]
// Function
// - Per-pin weak pull-ups, all on after reset
// - Pull-up off makes pin open drain
// - One pull-up register per port, consecutive
// - Latch-write strobe loads bus into latch
// - Latch read returns latch contents
// - Pin read returns sampled pin level
// - CPU picks latch or pin read path
// - Enabled peripheral takes over its pin
// - Latch zero drives low, one floats high
// - Modulated pin drives level XOR 38 kHz
// - Global modulation enable at config bit four
// - Eight modulation select bits in one register
// - Select bits map to eight pins, reset zero
// - Set bit disables pull-up, clear keeps it
`timescale 1ns/100ps

module parallel_port (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic [7:0]  SFR_ADDR,
  input  wire logic [7:0]  SFR_WDATA,
  input  wire logic        SFR_WR,
  input  wire logic        SFR_RD_LATCH,
  input  wire logic        SFR_RD_PIN,
  output var  logic [7:0]  SFR_RDATA,
  input  wire logic [23:0] PIN_IN,
  output var  logic [23:0] PIN_OUT,
  output var  logic [23:0] PIN_OE,
  output var  logic [23:0] PIN_PULLUP,
  input  wire logic [23:0] PERIPH_EN,
  input  wire logic [23:0] PERIPH_OUT
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] wr_byte(
    input logic [7:0] old,
    input logic [7:0] wd,
    input logic [7:0] mask,
    input logic       sel
  );
    return sel ? ((wd & mask) | (old & ~mask)) : old;
  endfunction

  function automatic logic [23:0] mod_mask(
    input logic [7:0] sel,
    input logic       en
  );
    logic [23:0] m;
    m = '0;
    for (int i = 0; i < port_pkg::NUM_MOD; i++) begin
      m[port_pkg::MOD_PIN[i]] = sel[i] & en;
    end
    return m;
  endfunction

  localparam logic [port_pkg::CNT_W-1:0] CNT_MAX =
    port_pkg::CNT_W'(port_pkg::CARRIER_HALF - 1);
  localparam logic [port_pkg::CNT_W-1:0] CNT_ONE =
    port_pkg::CNT_W'(1);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] latch      [port_pkg::NUM_PORTS];
  logic [7:0] next_latch [port_pkg::NUM_PORTS];
  logic [7:0] pu_dis      [port_pkg::NUM_PORTS];
  logic [7:0] next_pu_dis [port_pkg::NUM_PORTS];
  logic [7:0] mod_sel;
  logic [7:0] next_mod_sel;
  logic [7:0] cfg;
  logic [7:0] next_cfg;

  always_comb begin
    next_latch[0] = wr_byte(latch[0], SFR_WDATA, port_pkg::FULL_MASK,
      SFR_WR && SFR_ADDR == port_pkg::ADDR_PORT0);
    next_latch[1] = wr_byte(latch[1], SFR_WDATA, port_pkg::FULL_MASK,
      SFR_WR && SFR_ADDR == port_pkg::ADDR_PORT1);
    next_latch[2] = wr_byte(latch[2], SFR_WDATA, port_pkg::FULL_MASK,
      SFR_WR && SFR_ADDR == port_pkg::ADDR_PORT2);
    next_pu_dis[0] = wr_byte(pu_dis[0], SFR_WDATA, port_pkg::FULL_MASK,
      SFR_WR && SFR_ADDR == port_pkg::ADDR_PU0);
    next_pu_dis[1] = wr_byte(pu_dis[1], SFR_WDATA, port_pkg::FULL_MASK,
      SFR_WR && SFR_ADDR == port_pkg::ADDR_PU1);
    // Reserved bits stay clear so they always read back as zero
    next_pu_dis[2] = wr_byte(pu_dis[2], SFR_WDATA, port_pkg::PU2_MASK,
      SFR_WR && SFR_ADDR == port_pkg::ADDR_PU2);
    next_mod_sel = wr_byte(mod_sel, SFR_WDATA, port_pkg::FULL_MASK,
      SFR_WR && SFR_ADDR == port_pkg::ADDR_MOD_SEL);
    next_cfg = wr_byte(cfg, SFR_WDATA, port_pkg::CFG_MASK,
      SFR_WR && SFR_ADDR == port_pkg::ADDR_CFG);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int p = 0; p < port_pkg::NUM_PORTS; p++) begin
        latch[p]  <= port_pkg::LATCH_RESET;
        pu_dis[p] <= port_pkg::PU_RESET;
      end
      mod_sel <= port_pkg::MOD_SEL_RESET;
      cfg     <= port_pkg::CFG_RESET;
    end else if (CE) begin
      for (int p = 0; p < port_pkg::NUM_PORTS; p++) begin
        latch[p]  <= next_latch[p];
        pu_dis[p] <= next_pu_dis[p];
      end
      mod_sel <= next_mod_sel;
      cfg     <= next_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Read paths
  // ----------------------------------------------------------------
  // Pins are sampled once; the read path then sees a stable value
  logic [23:0] pin_sample;
  logic [7:0]  rdata;
  logic [7:0]  next_rdata;
  logic        use_latch;

  always_comb begin
    // Latch path wins when both strobes arrive together
    use_latch  = SFR_RD_LATCH;
    next_rdata = rdata;
    if (SFR_RD_LATCH || SFR_RD_PIN) begin
      unique case (SFR_ADDR)
        port_pkg::ADDR_PORT0:
          next_rdata = use_latch ? latch[0] : pin_sample[7:0];
        port_pkg::ADDR_PORT1:
          next_rdata = use_latch ? latch[1] : pin_sample[15:8];
        port_pkg::ADDR_PORT2:
          next_rdata = use_latch ? latch[2] : pin_sample[23:16];
        port_pkg::ADDR_MOD_SEL: next_rdata = mod_sel;
        port_pkg::ADDR_CFG:     next_rdata = cfg;
        port_pkg::ADDR_PU0:     next_rdata = pu_dis[0];
        port_pkg::ADDR_PU1:     next_rdata = pu_dis[1];
        port_pkg::ADDR_PU2:     next_rdata = pu_dis[2];
        default:                next_rdata = port_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata      <= '0;
      pin_sample <= '0;
    end else if (CE) begin
      rdata      <= next_rdata;
      pin_sample <= PIN_IN;
    end
  end

  assign SFR_RDATA = rdata;

  // ----------------------------------------------------------------
  // Carrier generator
  // ----------------------------------------------------------------
  // Free running so a newly enabled pin joins the same phase
  logic [port_pkg::CNT_W-1:0] carrier_cnt;
  logic [port_pkg::CNT_W-1:0] next_carrier_cnt;
  logic                       carrier;
  logic                       next_carrier;

  always_comb begin
    if (carrier_cnt == CNT_MAX) begin
      next_carrier_cnt = '0;
      next_carrier     = ~carrier;
    end else begin
      next_carrier_cnt = carrier_cnt + CNT_ONE;
      next_carrier     = carrier;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      carrier_cnt <= '0;
      carrier     <= 1'b0;
    end else if (CE) begin
      carrier_cnt <= next_carrier_cnt;
      carrier     <= next_carrier;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic [23:0] latch_all;
  logic [23:0] pu_all;
  logic [23:0] src;
  logic [23:0] level;
  logic [23:0] next_oe;
  logic [23:0] next_pullup;
  logic [23:0] pin_oe;
  logic [23:0] pin_pullup;
  logic [23:0] pin_out;

  always_comb begin
    latch_all = {latch[2], latch[1], latch[0]};
    pu_all    = {pu_dis[2], pu_dis[1], pu_dis[0]};
    src   = (PERIPH_EN & PERIPH_OUT) | (~PERIPH_EN & latch_all);
    level = src ^ (mod_mask(mod_sel, cfg[port_pkg::MOD_EN_BIT]) &
                   {port_pkg::NUM_PINS{carrier}});
    // High is never driven; it comes from the pull-up or outside
    next_oe     = ~level;
    next_pullup = ~pu_all;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_oe     <= '0;
      pin_pullup <= '1;
      pin_out    <= '0;
    end else if (CE) begin
      pin_oe     <= next_oe;
      pin_pullup <= next_pullup;
      pin_out    <= '0;
    end
  end

  assign PIN_OE     = pin_oe;
  assign PIN_PULLUP = pin_pullup;
  assign PIN_OUT    = pin_out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_pullup_after_reset;
    @(posedge CLK) disable iff (!RST_N)
      !$past(RST_N) |-> PIN_PULLUP == '1;
  endproperty
  a_pullup_after_reset: assert property (p_pullup_after_reset)
    else $error("Pull-ups not all on after reset");

  property p_never_high;
    @(posedge CLK) disable iff (!RST_N)
      PIN_OUT == '0;
  endproperty
  a_never_high: assert property (p_never_high)
    else $error("Pin actively driven high");

  property p_pullup_write;
    @(posedge CLK) disable iff (!RST_N)
      (CE && SFR_WR && SFR_ADDR == port_pkg::ADDR_PU0) ##1 CE ##1 CE
      |-> PIN_PULLUP[7:0] == ~$past(SFR_WDATA, 2);
  endproperty
  a_pullup_write: assert property (p_pullup_write)
    else $error("Pull-up disable write not seen at pins");

  property p_pu2_reserved;
    @(posedge CLK) disable iff (!RST_N)
      (CE && SFR_WR && SFR_ADDR == port_pkg::ADDR_PU2) ##1 !SFR_WR ##1
      (CE && SFR_RD_LATCH && !SFR_WR && SFR_ADDR == port_pkg::ADDR_PU2)
      |=> SFR_RDATA == ($past(SFR_WDATA, 3) & port_pkg::PU2_MASK);
  endproperty
  a_pu2_reserved: assert property (p_pu2_reserved)
    else $error("Port 2 pull-up readback wrong");

  property p_latch_roundtrip;
    @(posedge CLK) disable iff (!RST_N)
      (CE && SFR_WR && SFR_ADDR == port_pkg::ADDR_PORT0) ##1 !SFR_WR ##1
      (CE && SFR_RD_LATCH && !SFR_WR && SFR_ADDR == port_pkg::ADDR_PORT0)
      |=> SFR_RDATA == $past(SFR_WDATA, 3);
  endproperty
  a_latch_roundtrip: assert property (p_latch_roundtrip)
    else $error("Latch read does not return written value");

  property p_pin_read;
    @(posedge CLK) disable iff (!RST_N)
      (CE && $past(CE) && $past(RST_N) && SFR_RD_PIN && !SFR_RD_LATCH &&
       SFR_ADDR == port_pkg::ADDR_PORT1)
      |=> SFR_RDATA == $past(PIN_IN[15:8], 2);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("Pin read does not return pin level");

  property p_latch_priority;
    @(posedge CLK) disable iff (!RST_N)
      (CE && SFR_RD_LATCH && SFR_RD_PIN && !SFR_WR &&
       SFR_ADDR == port_pkg::ADDR_PORT0)
      |=> SFR_RDATA == $past(latch[0]);
  endproperty
  a_latch_priority: assert property (p_latch_priority)
    else $error("Latch path lost to pin path");

  property p_periph_owns;
    @(posedge CLK) disable iff (!RST_N)
      (CE && PERIPH_EN[0]) |=> PIN_OE[0] == !$past(PERIPH_OUT[0]);
  endproperty
  a_periph_owns: assert property (p_periph_owns)
    else $error("Peripheral does not control its pin");

  property p_gpio_drive;
    @(posedge CLK) disable iff (!RST_N)
      (CE && !PERIPH_EN[1]) |=> PIN_OE[1] == !$past(latch[0][1]);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive)
    else $error("Plain pin drive does not follow latch");

  property p_modulated;
    @(posedge CLK) disable iff (!RST_N)
      (CE && cfg[port_pkg::MOD_EN_BIT] && mod_sel[0] && !PERIPH_EN[3])
      |=> PIN_OE[3] == ($past(latch[0][3]) == $past(carrier));
  endproperty
  a_modulated: assert property (p_modulated)
    else $error("Modulated pin not latch xor carrier");

  property p_mod_gated;
    @(posedge CLK) disable iff (!RST_N)
      (CE && !cfg[port_pkg::MOD_EN_BIT] && !PERIPH_EN[3])
      |=> PIN_OE[3] == !$past(latch[0][3]);
  endproperty
  a_mod_gated: assert property (p_mod_gated)
    else $error("Pin modulated while global enable off");

  property p_carrier_half;
    @(posedge CLK) disable iff (!RST_N)
      (CE && carrier_cnt == CNT_MAX) |=> carrier != $past(carrier);
  endproperty
  a_carrier_half: assert property (p_carrier_half)
    else $error("Carrier did not toggle at half period");

endmodule

// [test/pin_partner.sv]
`timescale 1ns/100ps

module pin_partner (
  input  wire logic        clk,
  input  wire logic [23:0] pin_out,
  input  wire logic [23:0] pin_oe,
  input  wire logic [23:0] pin_pullup,
  input  wire logic [23:0] ext_low,
  output var  logic [23:0] pin_in
);

  // ----------------------------------------------------------------
  // Wire level seen by the outside world
  // ----------------------------------------------------------------
  logic [23:0] level;
  logic [23:0] last;

  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (pin_oe[i])
        level[i] = pin_out[i];
      else if (ext_low[i])
        level[i] = 1'b0;
      else if (pin_pullup[i])
        level[i] = 1'b1;
      else
        // Floating line: never trust a stale value
        level[i] = ~last[i];
    end
  end

  always_ff @(posedge clk) begin
    last   <= level;
    pin_in <= level;
  end

endmodule

// [test/testbench.sv]
`timescale 1ns/100ps

module testbench;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk;
  logic        rst_n;
  logic        ce;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd_l;
  logic        rd_p;
  logic [7:0]  rdata;
  logic [23:0] pin_in;
  logic [23:0] pin_out;
  logic [23:0] pin_oe;
  logic [23:0] pin_pu;
  logic [23:0] p_en;
  logic [23:0] p_out;
  logic [23:0] ext_low;
  logic [23:0] mod_mask;
  int          n_fail;
  int          tests_run;

  parallel_port dut_u (
    .CLK(clk), .RST_N(rst_n), .CE(ce),
    .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WR(wr),
    .SFR_RD_LATCH(rd_l), .SFR_RD_PIN(rd_p), .SFR_RDATA(rdata),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PIN_PULLUP(pin_pu), .PERIPH_EN(p_en), .PERIPH_OUT(p_out));

  pin_partner partner_u (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .ext_low(ext_low), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Strobe taken at the second edge, data settles just after it
  task automatic rd_reg(input logic [7:0] a, input logic latch,
                        output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_l <= latch;
    rd_p <= ~latch;
    @(posedge clk);
    rd_l <= 1'b0;
    rd_p <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Pins follow a register change one edge later
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Count carrier-high cycles on one pin and on the other modulated pins
  task automatic scan(input int pin, output int on, output int other);
    logic [23:0] m;
    m = mod_mask;
    m[pin] = 1'b0;
    on = 0;
    other = 0;
    repeat (2700) begin
      @(posedge clk);
      #1;
      if (pin_oe[pin] === 1'b1) on++;
      if ((pin_oe & m) !== 24'h000000) other++;
    end
  endtask

  // Cycles between two carrier edges on one pin; a stuck pin gives 2700
  task automatic half_period(input int pin, output int len);
    logic prev;
    int   k;
    len = 0;
    k = 0;
    prev = pin_oe[pin];
    while (k < 2700 && pin_oe[pin] === prev) begin
      @(posedge clk);
      #1;
      k++;
    end
    prev = pin_oe[pin];
    while (len < 2700 && pin_oe[pin] === prev) begin
      @(posedge clk);
      #1;
      len++;
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] a [7] = '{8'h80, 8'h90, 8'ha0, 8'hb2, 8'hb3, 8'hb4, 8'h9f};
    for (int i = 0; i < 7; i++) begin
      rd_reg(a[i], 1'b1, d);
      chk(24'(d), (i < 3) ? 24'hff : 24'h00);
    end
    chk(pin_pu, 24'hffffff);
    chk(pin_oe, 24'h000000);
    $display("reset values done");
  endtask

  task automatic t_latch();
    logic [7:0] d;
    wr_reg(port_pkg::ADDR_PORT0, 8'h5a);
    rd_reg(port_pkg::ADDR_PORT0, 1'b1, d);
    chk(24'(d), 24'h5a);
    settle();
    chk(24'(pin_oe[7:0]), 24'ha5);
    chk(pin_out, 24'h000000);
    // A pin pulled low outside reads low on the pin path only
    ext_low <= 24'h000002;
    settle();
    rd_reg(port_pkg::ADDR_PORT0, 1'b0, d);
    chk(24'(d), 24'h58);
    // Both strobes together: the latch path must win
    @(posedge clk);
    addr <= port_pkg::ADDR_PORT0;
    rd_l <= 1'b1;
    rd_p <= 1'b1;
    @(posedge clk);
    rd_l <= 1'b0;
    rd_p <= 1'b0;
    #1;
    chk(24'(rdata), 24'h5a);
    ext_low <= 24'h000000;
    // A write while the clock enable is low must be lost
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(port_pkg::ADDR_PORT0, 8'h00);
    ce <= 1'b1;
    rd_reg(port_pkg::ADDR_PORT0, 1'b1, d);
    chk(24'(d), 24'h5a);
    wr_reg(port_pkg::ADDR_PORT0, 8'hff);
    $display("latch path done");
  endtask

  task automatic t_pin_read();
    logic [7:0] d;
    ext_low <= 24'h000200;
    settle();
    rd_reg(port_pkg::ADDR_PORT1, 1'b0, d);
    chk(24'(d), 24'hfd);
    rd_reg(port_pkg::ADDR_PORT1, 1'b1, d);
    chk(24'(d), 24'hff);
    wr_reg(port_pkg::ADDR_PU1, 8'h01);
    ext_low <= 24'h000300;
    settle();
    rd_reg(port_pkg::ADDR_PORT1, 1'b0, d);
    chk(24'(d), 24'hfc);
    ext_low <= 24'h000000;
    wr_reg(port_pkg::ADDR_PU1, 8'h00);
    $display("pin path done");
  endtask

  task automatic t_pullup();
    logic [7:0] d;
    wr_reg(port_pkg::ADDR_PU0, 8'ha5);
    wr_reg(port_pkg::ADDR_PU1, 8'h3c);
    wr_reg(port_pkg::ADDR_PU2, 8'hff);
    rd_reg(port_pkg::ADDR_PU2, 1'b1, d);
    chk(24'(d), 24'h27);
    rd_reg(port_pkg::ADDR_PU1, 1'b1, d);
    chk(24'(d), 24'h3c);
    settle();
    chk(pin_pu, 24'hd8c35a);
    chk(pin_out, 24'h000000);
    rd_reg(8'h81, 1'b1, d);
    chk(24'(d), 24'h00);
    wr_reg(port_pkg::ADDR_PU0, 8'h00);
    wr_reg(port_pkg::ADDR_PU1, 8'h00);
    wr_reg(port_pkg::ADDR_PU2, 8'h00);
    $display("pull-up control done");
  endtask

  task automatic t_periph();
    // Latch stays set while the peripheral owns the pin
    p_en  <= 24'h020001;
    p_out <= 24'h000000;
    settle();
    chk(24'({pin_oe[17], pin_oe[0]}), 24'h3);
    @(posedge clk);
    p_out <= 24'h020001;
    settle();
    chk(24'({pin_oe[17], pin_oe[0]}), 24'h0);
    @(posedge clk);
    p_en <= 24'h000000;
    $display("peripheral takeover done");
  endtask

  task automatic t_mod();
    logic [7:0] d;
    int on;
    int other;
    int len;
    wr_reg(port_pkg::ADDR_MOD_SEL, 8'hff);
    rd_reg(port_pkg::ADDR_MOD_SEL, 1'b1, d);
    chk(24'(d), 24'hff);
    scan(port_pkg::MOD_PIN[0], on, other);
    chk(24'(on + other), 24'h0);
    wr_reg(port_pkg::ADDR_CFG, 8'hff);
    rd_reg(port_pkg::ADDR_CFG, 1'b1, d);
    chk(24'(d), 24'h10);
    for (int n = 0; n < 8; n++) begin
      wr_reg(port_pkg::ADDR_MOD_SEL, 8'h01 << n);
      settle();
      scan(port_pkg::MOD_PIN[n], on, other);
      chk(24'(on > 0 && on < 2700), 24'h1);
      chk(24'(other), 24'h0);
    end
    half_period(port_pkg::MOD_PIN[7], len);
    chk(24'(len), 24'(port_pkg::CARRIER_HALF));
    wr_reg(port_pkg::ADDR_CFG, 8'h00);
    wr_reg(port_pkg::ADDR_MOD_SEL, 8'h00);
    $display("carrier modulation done");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Watchdog: far beyond the longest legal run
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd_l = 1'b0;
    rd_p = 1'b0;
    p_en = 24'h000000;
    p_out = 24'h000000;
    ext_low = 24'h000000;
    n_fail = 0;
    tests_run = 0;
    mod_mask = 24'h000000;
    for (int n = 0; n < 8; n++)
      mod_mask[port_pkg::MOD_PIN[n]] = 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_latch();
    t_pin_read();
    t_pullup();
    t_periph();
    t_mod();
    finish_test();
  end

endmodule
